// *** hw/sdlc_frame_status_fifo.sv ***
// Frame status queue for bit-oriented reception with register read steering.
`timescale 1ns/1ns
module sdlc_frame_status_fifo (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CHANNEL_RESET,
    input wire logic [7:0] EXTENDED_FEATURE_CONTROL,
    input wire logic BIT_SYNC_MODE,
    input wire logic [1:0] RX_INT_MODE,
    input wire logic RX_CHAR_WRITTEN,
    input wire logic FRAME_END,
    input wire logic FRAME_ABORT,
    input wire logic [7:0] LIVE_LINE_STATUS,
    input wire logic [7:0] LIVE_COND_STATUS,
    input wire logic [7:0] LIVE_VECTOR,
    input wire logic [7:0] LIVE_PENDING,
    input wire logic DATA_TOP_EOF,
    input wire logic DATA_TOP_ERROR,
    input wire logic DATA_TOP_READ,
    input wire logic ERROR_RESET,
    input wire logic READ_STROBE,
    input wire logic [3:0] READ_ADDR,
    output logic [7:0] READ_DATA,
    output logic CRC_CHECK_RESET,
    output logic RX_DATA_INT,
    output logic SPECIAL_INT,
    output logic DATA_QUEUE_LOCK,
    output logic QUEUE_OVERFLOW,
    output logic QUEUE_AVAILABLE
);
    logic qen_r;
    logic [fsq_pkg::PTR_W-1:0] wptr_r, wptr_nxt;
    logic [fsq_pkg::PTR_W-1:0] rptr_r, rptr_nxt;
    logic [fsq_pkg::PTR_W:0] fill_r, fill_nxt;
    logic ovfl_r;
    logic avail_lat_r;
    logic popped_r;
    logic [fsq_pkg::COUNT_W-1:0] count_r, count_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic lock_r, rxint_r, spint_r, crc_r;
    logic [fsq_pkg::ENTRY_W-1:0] head;
    logic [fsq_pkg::ENTRY_W-1:0] push_data;

    wire enable_req = EXTENDED_FEATURE_CONTROL[fsq_pkg::BIT_QEN];
    wire active = qen_r && BIT_SYNC_MODE;
    wire clear = !RESETN || CHANNEL_RESET || !active;
    wire frame_done = FRAME_END || FRAME_ABORT;
    wire push = active && frame_done;
    wire full = (fill_r == fsq_pkg::FILL_FULL);
    wire empty = (fill_r == fsq_pkg::FILL_RESET);
    wire do_push = push && !full;
    wire rd_cond = READ_STROBE && (READ_ADDR == fsq_pkg::ADDR_COND);
    wire rd_hi = READ_STROBE && (READ_ADDR == fsq_pkg::ADDR_CNT_HI);
    wire from_queue = active && avail_lat_r && !empty;
    wire do_pop = rd_cond && from_queue && !popped_r;
    wire anti_lock = active && (RX_INT_MODE == fsq_pkg::RXI_SPECIAL_ONLY);
    wire lock_on_error = DATA_TOP_READ && DATA_TOP_ERROR;
    wire lock_on_eof = DATA_TOP_READ && DATA_TOP_EOF && !anti_lock;
    wire [fsq_pkg::PTR_W-1:0] wptr_inc = (wptr_r == fsq_pkg::PTR_LAST) ? fsq_pkg::PTR_RESET : wptr_r + 4'h1;
    wire [fsq_pkg::PTR_W-1:0] rptr_inc = (rptr_r == fsq_pkg::PTR_LAST) ? fsq_pkg::PTR_RESET : rptr_r + 4'h1;
    // Residue sits in bits 3..1, so the five stored bits are CRC, overrun and residue.
    wire [fsq_pkg::STAT_W-1:0] stat_in = {LIVE_COND_STATUS[fsq_pkg::BIT_CRC],
        LIVE_COND_STATUS[fsq_pkg::BIT_OVR], LIVE_COND_STATUS[3:1]};

    // A character arriving with the frame end is counted into the closing entry.
    wire [fsq_pkg::COUNT_W-1:0] count_cur = RX_CHAR_WRITTEN ? count_r + fsq_pkg::COUNT_ONE : count_r;

    assign push_data = {count_cur, stat_in};

    fsq_store u_store (
        .clk(CLK),
        .wr_en(do_push),
        .wr_addr(wptr_r),
        .wr_data(push_data),
        .rd_addr(do_pop ? rptr_inc : rptr_r),
        .rd_data(head)
    );

    wire [fsq_pkg::COUNT_W-1:0] head_cnt = head[fsq_pkg::ENTRY_W-1:fsq_pkg::STAT_W];
    wire [fsq_pkg::STAT_W-1:0] head_st = head[fsq_pkg::STAT_W-1:0];
    wire [7:0] queued_cond = {1'b1, head_st[4], head_st[3], LIVE_COND_STATUS[fsq_pkg::BIT_PAR],
        head_st[2:0], LIVE_COND_STATUS[fsq_pkg::BIT_SENT]};
    wire [7:0] cond_view = from_queue ? queued_cond : LIVE_COND_STATUS;
    // Count reads with the queue empty return the stale head; callers treat them as undefined.
    wire [7:0] hi_view = {ovfl_r, !empty, head_cnt[13:8]};
    wire [7:0] lo_view = head_cnt[7:0];

    always_comb
    begin
        rdata_nxt = rdata_r;
        if (READ_STROBE)
        begin
            unique case (READ_ADDR)
                fsq_pkg::ADDR_LINE, fsq_pkg::ADDR_MLINE: rdata_nxt = LIVE_LINE_STATUS;
                fsq_pkg::ADDR_COND, fsq_pkg::ADDR_MCOND: rdata_nxt = cond_view;
                fsq_pkg::ADDR_VEC: rdata_nxt = LIVE_VECTOR;
                fsq_pkg::ADDR_PEND: rdata_nxt = LIVE_PENDING;
                fsq_pkg::ADDR_CNT_LO: rdata_nxt = active ? lo_view : LIVE_VECTOR;
                fsq_pkg::ADDR_CNT_HI: rdata_nxt = active ? hi_view : LIVE_PENDING;
                fsq_pkg::ADDR_EXT_RB: rdata_nxt = {5'h00, qen_r, 2'h0};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        wptr_nxt = do_push ? wptr_inc : wptr_r;
        rptr_nxt = do_pop ? rptr_inc : rptr_r;
        fill_nxt = fill_r + {4'h0, do_push} - {4'h0, do_pop};
        count_nxt = frame_done ? fsq_pkg::COUNT_RESET : count_cur;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            qen_r <= 1'b0;
        end
        else
        begin
            qen_r <= enable_req;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (clear)
        begin
            wptr_r <= fsq_pkg::PTR_RESET;
            rptr_r <= fsq_pkg::PTR_RESET;
            fill_r <= fsq_pkg::FILL_RESET;
        end
        else
        begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            fill_r <= fill_nxt;
        end
    end

    // Overflow falls only on reset, channel reset or while the queue is inactive, so a host must reset or re-enable to recover.
    always_ff @(posedge CLK)
    begin
        if (clear)
        begin
            ovfl_r <= 1'b0;
        end
        else
        begin
            ovfl_r <= ovfl_r || (push && full);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (clear)
        begin
            avail_lat_r <= 1'b0;
            popped_r <= 1'b0;
        end
        else
        begin
            avail_lat_r <= rd_hi ? !empty : avail_lat_r;
            popped_r <= rd_hi ? 1'b0 : (popped_r || do_pop);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN || CHANNEL_RESET)
        begin
            count_r <= fsq_pkg::COUNT_RESET;
            rdata_r <= 8'h00;
            crc_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            rdata_r <= rdata_nxt;
            crc_r <= FRAME_END;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN || CHANNEL_RESET)
        begin
            lock_r <= 1'b0;
            rxint_r <= 1'b0;
            spint_r <= 1'b0;
        end
        else
        begin
            rxint_r <= anti_lock && DATA_TOP_EOF;
            spint_r <= lock_on_error;
            // The lock is set by an error character even in the error reset cycle.
            lock_r <= lock_on_error || lock_on_eof || (lock_r && !ERROR_RESET);
        end
    end

    assign READ_DATA = rdata_r;
    assign CRC_CHECK_RESET = crc_r;
    assign RX_DATA_INT = rxint_r;
    assign SPECIAL_INT = spint_r;
    assign DATA_QUEUE_LOCK = lock_r;
    assign QUEUE_OVERFLOW = ovfl_r;
    assign QUEUE_AVAILABLE = !empty;

    a_fill_bound: assert property (@(posedge CLK) disable iff (!RESETN) fill_r <= fsq_pkg::FILL_FULL)
        else $error("queue fill above ten");
    a_disable_clear: assert property (@(posedge CLK) disable iff (!RESETN) !active |=> fill_r == 5'h00)
        else $error("queue not cleared while disabled");
    a_push_grows: assert property (@(posedge CLK) disable iff (!RESETN)
        (!clear && do_push && !do_pop) |=> fill_r == $past(fill_r) + 5'h01)
        else $error("push did not grow queue");
    a_ovfl_sticky: assert property (@(posedge CLK) disable iff (!RESETN)
        (ovfl_r && active && !CHANNEL_RESET) |=> ovfl_r)
        else $error("overflow flag dropped while enabled");
    a_ovfl_set: assert property (@(posedge CLK) disable iff (!RESETN) (!clear && push && full) |=> ovfl_r)
        else $error("overflow not flagged");
    a_no_underflow: assert property (@(posedge CLK) disable iff (!RESETN) empty |-> !do_pop)
        else $error("pop from empty queue");
    a_single_pop: assert property (@(posedge CLK) disable iff (!RESETN)
        (do_pop && !rd_hi) ##1 (rd_cond && !rd_hi && !clear) |-> !do_pop)
        else $error("second pop without high count read");
    a_readback_en: assert property (@(posedge CLK) disable iff (!RESETN)
        (READ_STROBE && READ_ADDR == fsq_pkg::ADDR_EXT_RB && !CHANNEL_RESET) |=> READ_DATA[2] == $past(qen_r))
        else $error("enable readback wrong");
    a_count_clear: assert property (@(posedge CLK) disable iff (!RESETN)
        (frame_done && !CHANNEL_RESET) |=> count_r == fsq_pkg::COUNT_RESET)
        else $error("counter not cleared at frame end");
    a_eof_one: assert property (@(posedge CLK) disable iff (!RESETN)
        (rd_cond && from_queue && !CHANNEL_RESET) |=> READ_DATA[7])
        else $error("queued status lacks end of frame");
    a_pop_shrinks: assert property (@(posedge CLK) disable iff (!RESETN)
        (!clear && do_pop && !do_push) |=> fill_r == $past(fill_r) - 5'h01)
        else $error("pop did not shrink queue");
    a_full_drop: assert property (@(posedge CLK) disable iff (!RESETN)
        (!clear && push && full && !do_pop) |=> fill_r == fsq_pkg::FILL_FULL && wptr_r == $past(wptr_r))
        else $error("push accepted into full queue");
    a_wptr_step: assert property (@(posedge CLK) disable iff (!RESETN)
        (!clear && do_push) |=> wptr_r == $past(wptr_inc))
        else $error("write pointer did not advance");
    a_rptr_hold: assert property (@(posedge CLK) disable iff (!RESETN)
        (!clear && !do_pop) |=> rptr_r == $past(rptr_r))
        else $error("read pointer moved without a pop");
    a_hi_avail: assert property (@(posedge CLK) disable iff (!RESETN)
        (rd_hi && active && !CHANNEL_RESET) |=> READ_DATA[fsq_pkg::BIT_AVAIL] == $past(QUEUE_AVAILABLE))
        else $error("available bit wrong in high count");
    a_hi_ovfl: assert property (@(posedge CLK) disable iff (!RESETN)
        (rd_hi && active && !CHANNEL_RESET) |=> READ_DATA[fsq_pkg::BIT_OVFL] == $past(ovfl_r))
        else $error("overflow bit wrong in high count");
    a_mirror_line: assert property (@(posedge CLK) disable iff (!RESETN)
        (READ_STROBE && READ_ADDR == fsq_pkg::ADDR_MLINE && !CHANNEL_RESET) |=> READ_DATA == $past(LIVE_LINE_STATUS))
        else $error("line status mirror wrong");
    a_mirror_vec: assert property (@(posedge CLK) disable iff (!RESETN)
        (READ_STROBE && READ_ADDR == fsq_pkg::ADDR_CNT_LO && !active && !CHANNEL_RESET) |=> READ_DATA == $past(LIVE_VECTOR))
        else $error("vector mirror wrong while disabled");
    a_mirror_pend: assert property (@(posedge CLK) disable iff (!RESETN)
        (READ_STROBE && READ_ADDR == fsq_pkg::ADDR_CNT_HI && !active && !CHANNEL_RESET) |=> READ_DATA == $past(LIVE_PENDING))
        else $error("pending mirror wrong while disabled");
    a_live_parity: assert property (@(posedge CLK) disable iff (!RESETN)
        (rd_cond && !CHANNEL_RESET) |=> READ_DATA[fsq_pkg::BIT_PAR] == $past(LIVE_COND_STATUS[fsq_pkg::BIT_PAR]))
        else $error("parity bit not live");
    a_live_sent: assert property (@(posedge CLK) disable iff (!RESETN)
        (rd_cond && !CHANNEL_RESET) |=> READ_DATA[fsq_pkg::BIT_SENT] == $past(LIVE_COND_STATUS[fsq_pkg::BIT_SENT]))
        else $error("all sent bit not live");
    a_live_status: assert property (@(posedge CLK) disable iff (!RESETN)
        (rd_cond && !from_queue && !CHANNEL_RESET) |=> READ_DATA == $past(LIVE_COND_STATUS))
        else $error("status not live without queue");
    a_queued_head: assert property (@(posedge CLK) disable iff (!RESETN)
        (rd_cond && from_queue && !CHANNEL_RESET) |=> READ_DATA[6:5] == $past(head_st[4:3]))
        else $error("queued status not from head");
    a_crc_pulse: assert property (@(posedge CLK) disable iff (!RESETN)
        (FRAME_END && !CHANNEL_RESET) |=> CRC_CHECK_RESET)
        else $error("checker not reset at frame end");
    a_rxint_mode: assert property (@(posedge CLK) disable iff (!RESETN)
        (!anti_lock && !CHANNEL_RESET) |=> !RX_DATA_INT)
        else $error("receive data interrupt outside anti-lock");
    a_eof_no_lock: assert property (@(posedge CLK) disable iff (!RESETN)
        (lock_on_eof == 1'b0 && DATA_TOP_READ && DATA_TOP_EOF && !DATA_TOP_ERROR && !lock_r) |=> !DATA_QUEUE_LOCK)
        else $error("end of frame locked in anti-lock mode");
    a_error_lock: assert property (@(posedge CLK) disable iff (!RESETN)
        (DATA_TOP_READ && DATA_TOP_ERROR && !CHANNEL_RESET) |=> DATA_QUEUE_LOCK && SPECIAL_INT)
        else $error("error character did not lock");
    a_count_step: assert property (@(posedge CLK) disable iff (!RESETN)
        (RX_CHAR_WRITTEN && !frame_done && !CHANNEL_RESET) |=> count_r == $past(count_r) + fsq_pkg::COUNT_ONE)
        else $error("counter missed a character");
    a_reset_off: assert property (@(posedge CLK)
        !RESETN |=> !qen_r && READ_DATA == 8'h00)
        else $error("enable or read data not cleared by reset");
endmodule

// *** hw/fsq_pkg.sv ***
// Constants shared by the frame status queue files.
package fsq_pkg;
    localparam int DEPTH = 10;
    localparam int PTR_W = 4;
    localparam int COUNT_W = 14;
    localparam int STAT_W = 5;
    localparam int ENTRY_W = COUNT_W + STAT_W;
    localparam logic [PTR_W-1:0] PTR_LAST = 4'h9;
    localparam logic [PTR_W:0] FILL_FULL = 5'h0a;
    localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
    localparam logic [PTR_W:0] FILL_RESET = 5'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 14'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 14'h0001;
    // Register read addresses.
    localparam logic [3:0] ADDR_LINE = 4'h0;
    localparam logic [3:0] ADDR_COND = 4'h1;
    localparam logic [3:0] ADDR_VEC = 4'h2;
    localparam logic [3:0] ADDR_PEND = 4'h3;
    localparam logic [3:0] ADDR_MLINE = 4'h4;
    localparam logic [3:0] ADDR_MCOND = 4'h5;
    localparam logic [3:0] ADDR_CNT_LO = 4'h6;
    localparam logic [3:0] ADDR_CNT_HI = 4'h7;
    localparam logic [3:0] ADDR_EXT_RB = 4'hf;
    // Bit positions, and the receive interrupt mode code.
    localparam int BIT_QEN = 2;
    localparam int BIT_AVAIL = 6;
    localparam int BIT_OVFL = 7;
    localparam int BIT_EOF = 7;
    localparam int BIT_CRC = 6;
    localparam int BIT_OVR = 5;
    localparam int BIT_PAR = 4;
    localparam int BIT_SENT = 0;
    localparam logic [1:0] RXI_SPECIAL_ONLY = 2'h3;
endpackage

// *** hw/fsq_store.sv ***
// Ten-entry memory holding queued frame counts and status, registered read port.
`timescale 1ns/1ns
module fsq_store (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [fsq_pkg::PTR_W-1:0] wr_addr,
    input wire logic [fsq_pkg::ENTRY_W-1:0] wr_data,
    input wire logic [fsq_pkg::PTR_W-1:0] rd_addr,
    output logic [fsq_pkg::ENTRY_W-1:0] rd_data
);
    logic [fsq_pkg::ENTRY_W-1:0] mem [fsq_pkg::DEPTH];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// *** testbench/frame_source.sv ***
// Behavioural receive channel that writes characters and then ends or aborts a frame.
`timescale 1ns/1ns
module frame_source (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] n,
    input wire logic abort,
    output logic char_wr,
    output logic frame_end,
    output logic frame_abort,
    output logic busy
);
    logic [7:0] left_r;
    initial
    begin
        {char_wr, frame_end, frame_abort, busy, left_r} = 12'h000;
    end
    // One character per cycle gives the densest traffic the counter must follow.
    always @(posedge clk)
    begin
        char_wr <= 1'b0;
        frame_end <= 1'b0;
        frame_abort <= 1'b0;
        if (go && !busy)
        begin
            left_r <= n;
            busy <= 1'b1;
        end
        else if (busy && left_r != 8'h00)
        begin
            char_wr <= 1'b1;
            left_r <= left_r - 8'h01;
        end
        else if (busy)
        begin
            frame_end <= !abort;
            frame_abort <= abort;
            busy <= 1'b0;
        end
    end
endmodule

// *** testbench/sdlc_frame_status_fifo_tb.sv ***
// Self-checking bench for the frame status queue.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end
module sdlc_frame_status_fifo_tb;
    logic clk = 1'b0, resetn = 1'b0, chan_rst = 1'b0, sync = 1'b1, go = 1'b0, abort = 1'b0;
    logic top_eof = 1'b0, top_err = 1'b0, top_rd = 1'b0, err_rst = 1'b0, strobe = 1'b0;
    logic [7:0] ext = 8'h00, line = 8'h21, cond = 8'h00, vec = 8'h5a, pend = 8'h3c, n = 8'h00, rd_data;
    logic [1:0] mode = 2'h0;
    logic [3:0] addr = 4'h0;
    logic char_wr, fend, fabort, busy, crc_rst, dint, sint, lock, ovfl, avail;
    int err_count = 0;
    int tests_run = 0;
    int j;
    frame_source src (.clk(clk), .go(go), .n(n), .abort(abort), .char_wr(char_wr), .frame_end(fend),
        .frame_abort(fabort), .busy(busy));
    sdlc_frame_status_fifo uut (.CLK(clk), .RESETN(resetn), .CHANNEL_RESET(chan_rst),
        .EXTENDED_FEATURE_CONTROL(ext), .BIT_SYNC_MODE(sync), .RX_INT_MODE(mode), .RX_CHAR_WRITTEN(char_wr),
        .FRAME_END(fend), .FRAME_ABORT(fabort), .LIVE_LINE_STATUS(line), .LIVE_COND_STATUS(cond),
        .LIVE_VECTOR(vec), .LIVE_PENDING(pend), .DATA_TOP_EOF(top_eof), .DATA_TOP_ERROR(top_err),
        .DATA_TOP_READ(top_rd), .ERROR_RESET(err_rst), .READ_STROBE(strobe), .READ_ADDR(addr),
        .READ_DATA(rd_data), .CRC_CHECK_RESET(crc_rst), .RX_DATA_INT(dint), .SPECIAL_INT(sint),
        .DATA_QUEUE_LOCK(lock), .QUEUE_OVERFLOW(ovfl), .QUEUE_AVAILABLE(avail));
    task automatic final_report();
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    // Read data is sampled one edge late because it holds until the next strobe.
    task automatic rd(logic [3:0] a, logic [7:0] want);
        addr = a;
        strobe = 1'b1;
        tick(1);
        strobe = 1'b0;
        tick(1);
        `CHK(rd_data, want)
    endtask
    task automatic frame(logic [7:0] k, logic ab);
        int i;
        n = k;
        abort = ab;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (i = 0; i < 300 && busy === 1'b1; i++)
            tick(1);
        if (i == 300)
        begin
            err_count++;
            final_report();
        end
        tick(1);
        `CHK(crc_rst, !ab)
        tick(2);
    endtask
    initial
    begin
        forever #20 clk = ~clk;
    end
    initial
    begin
        tick(12);
        resetn = 1'b1;
        rd(4'hf, 8'h00);
        rd(4'h0, line);
        rd(4'h2, vec);
        rd(4'h3, pend);
        rd(4'h4, line);
        rd(4'h5, cond);
        rd(4'h6, vec);
        rd(4'h7, pend);
        frame(8'h02, 1'b0);
        `CHK(avail, 1'b0)
        ext = 8'h04;
        tick(2);
        rd(4'hf, 8'h04);
        frame(8'h00, 1'b0);
        chan_rst = 1'b1;
        tick(1);
        chan_rst = 1'b0;
        tick(1);
        `CHK(avail, 1'b0)
        cond = 8'h4a;
        frame(8'h03, 1'b0);
        cond = 8'h00;
        frame(8'h05, 1'b1);
        cond = 8'h31;
        `CHK(avail, 1'b1)
        rd(4'h7, 8'h40);
        rd(4'h6, 8'h03);
        rd(4'h1, 8'hdb);
        rd(4'h1, 8'h91);
        rd(4'h7, 8'h40);
        rd(4'h6, 8'h05);
        rd(4'h1, 8'h91);
        `CHK(avail, 1'b0)
        rd(4'h1, 8'h31);
        for (j = 0; j < 10; j++)
            frame(8'h00, 1'b0);
        `CHK(ovfl, 1'b0)
        frame(8'h00, 1'b0);
        `CHK(ovfl, 1'b1)
        rd(4'h7, 8'hc0);
        ext = 8'h00;
        tick(2);
        `CHK(avail, 1'b0)
        ext = 8'h04;
        tick(2);
        `CHK(ovfl, 1'b0)
        sync = 1'b0;
        frame(8'h01, 1'b0);
        `CHK(avail, 1'b0)
        sync = 1'b1;
        mode = 2'h3;
        top_eof = 1'b1;
        tick(2);
        `CHK(dint, 1'b1)
        top_rd = 1'b1;
        tick(1);
        top_rd = 1'b0;
        tick(1);
        `CHK(lock, 1'b0)
        // The service routine ends here; its in-service clear goes to the interrupt logic.
        top_eof = 1'b0;
        top_err = 1'b1;
        top_rd = 1'b1;
        tick(1);
        top_rd = 1'b0;
        `CHK(sint, 1'b1)
        tick(1);
        `CHK(lock, 1'b1)
        err_rst = 1'b1;
        tick(1);
        err_rst = 1'b0;
        tick(1);
        `CHK(lock, 1'b0)
        mode = 2'h0;
        top_err = 1'b0;
        top_eof = 1'b1;
        top_rd = 1'b1;
        tick(1);
        top_rd = 1'b0;
        `CHK(dint, 1'b0)
        `CHK(lock, 1'b1)
        resetn = 1'b0;
        tick(1);
        resetn = 1'b1;
        rd(4'hf, 8'h00);
        final_report();
    end
endmodule
